// ---- include/irq_unit_pkg.sv ----
package irq_unit_pkg;

  // register offsets on the host register port
  localparam logic [7:0] ENABLE_OFFSET = 8'hF0;
  localparam logic [7:0] PENDING_OFFSET = 8'hF1;

  // source count and bit positions inside both registers
  localparam int NUM_SRC = 5;
  localparam int KEY_BIT = 4;
  localparam int DMA_BIT = 3;
  localparam int TOUCH_BIT = 2;
  localparam int XFER_DONE_BIT = 1;
  localparam int SHARED_BIT = 0;

  // values after reset
  localparam logic [NUM_SRC-1:0] ENABLE_RESET = 5'h00;
  localparam logic [NUM_SRC-1:0] PENDING_RESET = 5'h00;
  localparam logic [7:0] READ_RESET = 8'h00;
  localparam logic [2:0] UNUSED_BITS = 3'h0;

  // block-transfer operation codes that involve host data
  localparam logic [3:0] OP_WRITE_RASTER = 4'h0;
  localparam logic [3:0] OP_READ = 4'h1;
  localparam logic [3:0] OP_TRANSPARENT_WRITE = 4'h4;
  localparam logic [3:0] OP_COLOR_EXPAND = 4'h8;
  localparam logic [3:0] OP_COLOR_EXPAND_TRANSP = 4'h9;

  // one host register access, same clock as the block
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_req_t;

  // one-cycle event pulses from the generators
  typedef struct packed {
    logic key;
    logic dma;
    logic touch;
    logic xfer_done;
    logic host_rw;
    logic font_done;
  } irq_event_t;

endpackage : irq_unit_pkg

// ---- src/irq_flag_bank.sv ----
`timescale 1ns/1ps

module irq_flag_bank #(
  parameter int WIDTH = 5,
  parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
  input wire logic mclk_in,
  input wire logic rst_n_in,
  input wire logic [WIDTH-1:0] set_in,
  input wire logic [WIDTH-1:0] clear_in,
  output logic [WIDTH-1:0] flag_out
);

  genvar i;
  generate
    for (i = 0; i < WIDTH; i = i + 1) begin : g_flag
      // sticky flag, set beats clear
      always_ff @(posedge mclk_in) begin
        if (!rst_n_in) begin
          flag_out[i] <= RESET_VALUE[i];
        end else if (set_in[i]) begin
          flag_out[i] <= 1'b1;
        end else if (clear_in[i]) begin
          flag_out[i] <= 1'b0;
        end
      end
    end
  endgenerate

  default clocking cb @(posedge mclk_in);
  endclocking
  default disable iff (!rst_n_in);

  AST_SET_WINS: assert property (
    (rst_n_in && (|set_in)) |=> ((flag_out & $past(set_in)) == $past(set_in)))
    else $error("flag set lost");
  AST_HOLD_WITHOUT_CLEAR: assert property (
    ((flag_out & ~clear_in) != '0)
    |=> ((flag_out & $past(flag_out & ~clear_in)) == $past(flag_out & ~clear_in)))
    else $error("flag dropped without clear");

endmodule : irq_flag_bank

// ---- src/display_ctrl_irq_unit.sv ----
`timescale 1ns/1ps

module display_ctrl_irq_unit (
  input wire logic mclk_in,
  input wire logic rst_n_in,
  input wire irq_unit_pkg::reg_req_t req_in,
  input wire irq_unit_pkg::irq_event_t event_in,
  input wire logic engine_on_in,
  input wire logic [3:0] xfer_op_in,
  input wire logic text_mode_in,
  output logic [7:0] rdata_out,
  output logic irq_out
);

  logic [irq_unit_pkg::NUM_SRC-1:0] enable;
  logic [irq_unit_pkg::NUM_SRC-1:0] pending;
  logic [irq_unit_pkg::NUM_SRC-1:0] set_vec;
  logic [irq_unit_pkg::NUM_SRC-1:0] clear_vec;
  logic host_mode;
  logic font_mode;
  logic enable_wr;
  logic pending_wr;

  // host-related operation decode
  function automatic logic is_host_op(input logic [3:0] op);
    logic hit;
    hit = 1'b0;
    case (op)
      irq_unit_pkg::OP_WRITE_RASTER: hit = 1'b1;
      irq_unit_pkg::OP_READ: hit = 1'b1;
      irq_unit_pkg::OP_TRANSPARENT_WRITE: hit = 1'b1;
      irq_unit_pkg::OP_COLOR_EXPAND: hit = 1'b1;
      irq_unit_pkg::OP_COLOR_EXPAND_TRANSP: hit = 1'b1;
      default: hit = 1'b0;
    endcase
    return hit;
  endfunction : is_host_op

  assign host_mode = engine_on_in && is_host_op(xfer_op_in);
  assign font_mode = !engine_on_in && text_mode_in;
  assign enable_wr = req_in.wr && (req_in.addr == irq_unit_pkg::ENABLE_OFFSET);
  assign pending_wr = req_in.wr && (req_in.addr == irq_unit_pkg::PENDING_OFFSET);

  // enable register
  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      enable <= irq_unit_pkg::ENABLE_RESET;
    end else if (enable_wr) begin
      enable <= req_in.wdata[irq_unit_pkg::NUM_SRC-1:0];
    end
  end

  // event routing into the status flags
  always_comb begin
    set_vec = '0;
    set_vec[irq_unit_pkg::KEY_BIT] = event_in.key;
    set_vec[irq_unit_pkg::DMA_BIT] = event_in.dma;
    set_vec[irq_unit_pkg::TOUCH_BIT] = event_in.touch;
    set_vec[irq_unit_pkg::XFER_DONE_BIT] = event_in.xfer_done;
    set_vec[irq_unit_pkg::SHARED_BIT] = (host_mode && event_in.host_rw)
      || (font_mode && event_in.font_done);
  end

  // write one clears, write zero leaves alone
  assign clear_vec = pending_wr ? req_in.wdata[irq_unit_pkg::NUM_SRC-1:0] : '0;

  irq_flag_bank #(
    .WIDTH(irq_unit_pkg::NUM_SRC),
    .RESET_VALUE(irq_unit_pkg::PENDING_RESET)
  ) u_flags (
    .mclk_in(mclk_in),
    .rst_n_in(rst_n_in),
    .set_in(set_vec),
    .clear_in(clear_vec),
    .flag_out(pending)
  );

  // read data, held between reads
  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      rdata_out <= irq_unit_pkg::READ_RESET;
    end else if (req_in.rd) begin
      case (req_in.addr)
        irq_unit_pkg::ENABLE_OFFSET: begin
          rdata_out <= {irq_unit_pkg::UNUSED_BITS, enable};
        end
        irq_unit_pkg::PENDING_OFFSET: begin
          rdata_out <= {irq_unit_pkg::UNUSED_BITS, pending};
        end
        default: begin
          rdata_out <= irq_unit_pkg::READ_RESET;
        end
      endcase
    end
  end

  // interrupt request
  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      irq_out <= 1'b0;
    end else begin
      irq_out <= |(pending & enable);
    end
  end

  default clocking cb @(posedge mclk_in);
  endclocking
  default disable iff (!rst_n_in);

  AST_ENABLE_READBACK: assert property (
    enable_wr ##1 !enable_wr ##1 (req_in.rd && (req_in.addr == irq_unit_pkg::ENABLE_OFFSET) && !enable_wr)
    |=> (rdata_out == {3'h0, $past(req_in.wdata[4:0], 3)}))
    else $error("enable readback mismatch");
  AST_KEY_GATED_ON: assert property (
    (pending[4] && enable[4]) |=> irq_out)
    else $error("enabled key flag gave no irq");
  AST_MASKED_QUIET: assert property (
    ((pending & enable) == 5'h00) |=> !irq_out)
    else $error("irq without enabled flag");
  AST_IRQ_CAUSE: assert property (
    irq_out |-> ($past(pending & enable) != 5'h00))
    else $error("irq has no cause");
  AST_HOST_RW_SET: assert property (
    (rst_n_in && engine_on_in && is_host_op(xfer_op_in) && event_in.host_rw) |=> pending[0])
    else $error("host rw event lost");
  AST_NON_HOST_OP: assert property (
    (engine_on_in && !is_host_op(xfer_op_in) && !pending[0]) |=> !pending[0])
    else $error("bit 0 set by non-host operation");
  AST_FONT_SET: assert property (
    (rst_n_in && !engine_on_in && text_mode_in && event_in.font_done)
    |=> pending[0] ##1 (pending[0] || $past(clear_vec[0])))
    else $error("font event lost");
  AST_DMA_SET: assert property (
    (rst_n_in && event_in.dma) |=> pending[3])
    else $error("dma event lost");
  AST_KEY_CLEAR: assert property (
    (pending_wr && req_in.wdata[4] && !event_in.key) |=> !pending[4])
    else $error("key flag not cleared");
  AST_TOUCH_ZERO_WRITE: assert property (
    (pending[2] && pending_wr && !req_in.wdata[2]) |=> pending[2])
    else $error("write zero cleared touch flag");
  AST_STATUS_READ: assert property (
    (req_in.rd && (req_in.addr == irq_unit_pkg::PENDING_OFFSET)) |=> (rdata_out == {3'h0, $past(pending)}))
    else $error("status read mismatch");
  AST_ENABLE_WRITE: assert property (
    enable_wr |=> (enable == $past(req_in.wdata[4:0])))
    else $error("enable write lost");
  AST_ENABLE_HOLD: assert property (
    !enable_wr |=> $stable(enable))
    else $error("enable changed without write");
  AST_KEY_SET: assert property (
    (rst_n_in && event_in.key) |=> pending[4])
    else $error("key event lost");
  AST_TOUCH_SET: assert property (
    (rst_n_in && event_in.touch) |=> pending[2])
    else $error("touch event lost");
  AST_XFER_DONE_SET: assert property (
    (rst_n_in && event_in.xfer_done) |=> pending[1])
    else $error("transfer done event lost");
  AST_DMA_CLEAR: assert property (
    (pending_wr && req_in.wdata[3] && !event_in.dma) |=> !pending[3])
    else $error("dma flag not cleared");
  AST_TOUCH_CLEAR: assert property (
    (pending_wr && req_in.wdata[2] && !event_in.touch) |=> !pending[2])
    else $error("touch flag not cleared");
  AST_XFER_DONE_CLEAR: assert property (
    (pending_wr && req_in.wdata[1] && !event_in.xfer_done) |=> !pending[1])
    else $error("transfer done flag not cleared");
  AST_SHARED_CLEAR: assert property (
    (pending_wr && req_in.wdata[0] && !set_vec[0]) |=> !pending[0])
    else $error("shared flag not cleared");
  AST_NO_SPONTANEOUS_SET: assert property (
    ((pending & ~$past(pending) & ~$past(set_vec)) == 5'h00))
    else $error("flag set without event");
  AST_FONT_NEEDS_TEXT: assert property (
    (!engine_on_in && !text_mode_in && !pending[0]) |=> !pending[0])
    else $error("bit 0 set outside text mode");
  AST_ENGINE_OFF_DROPS_HOST: assert property (
    (!engine_on_in && !event_in.font_done && !pending[0]) |=> !pending[0])
    else $error("host rw taken with engine off");
  AST_SHARED_GATED_ON: assert property (
    (pending[0] && enable[0]) |=> irq_out)
    else $error("enabled shared flag gave no irq");
  AST_DMA_GATED_ON: assert property (
    (pending[3] && enable[3]) |=> irq_out)
    else $error("enabled dma flag gave no irq");
  AST_TOUCH_GATED_ON: assert property (
    (pending[2] && enable[2]) |=> irq_out)
    else $error("enabled touch flag gave no irq");
  AST_XFER_DONE_GATED_ON: assert property (
    (pending[1] && enable[1]) |=> irq_out)
    else $error("enabled transfer done flag gave no irq");
  AST_READ_HOLD: assert property (
    !req_in.rd |=> $stable(rdata_out))
    else $error("read data changed without read");
  AST_UNKNOWN_ADDR_READ: assert property (
    (req_in.rd && (req_in.addr != irq_unit_pkg::ENABLE_OFFSET) && (req_in.addr != irq_unit_pkg::PENDING_OFFSET))
    |=> (rdata_out == 8'h00))
    else $error("unmapped read not zero");
  AST_UPPER_ZERO: assert property (
    (rdata_out[7:5] == 3'h0))
    else $error("upper read bits not zero");

  COV_KEY_IRQ: cover property (event_in.key && enable[4] ##2 irq_out);
  COV_FONT_FLAG: cover property (font_mode && event_in.font_done ##1 pending[0]);
  COV_HOST_FLAG: cover property (host_mode && event_in.host_rw ##1 pending[0]);
  COV_CLEAR_SET_SAME: cover property (pending_wr && req_in.wdata[3] && event_in.dma);

endmodule : display_ctrl_irq_unit

// ---- tb/host_model.sv ----
`timescale 1ns/1ps

module host_model (
  input wire logic mclk_in,
  output irq_unit_pkg::reg_req_t req_out
);
  initial req_out = '0;

  // one strobe per access, released at the next edge
  task automatic access(input logic wr, input logic [7:0] addr, input logic [7:0] wdata);
    @(posedge mclk_in);
    req_out <= '{wr: wr, rd: !wr, addr: addr, wdata: wdata};
    @(posedge mclk_in);
    req_out <= '{wr: 1'b0, rd: 1'b0, addr: ~addr, wdata: ~wdata};
  endtask : access
endmodule : host_model

// ---- tb/tb_display_ctrl_irq_unit.sv ----
`timescale 1ns/1ps

module tb_display_ctrl_irq_unit;
  logic mclk_in = 1'b0;
  logic rst_n = 1'b0;
  logic rnd_on = 1'b0;
  irq_unit_pkg::reg_req_t req;
  irq_unit_pkg::irq_event_t ev = '0;
  logic eng = 1'b0;
  logic [3:0] op = 4'h0;
  logic txt = 1'b0;
  logic [7:0] rdata;
  logic irq;
  logic [31:0] seed = 32'hDEDB;
  logic [31:0] hs;
  int m_en, m_pend, m_rdata, m_irq, sh;
  int errors = 0;
  int tests_run = 0;

  always #5 mclk_in = ~mclk_in;

  host_model host_model_inst (.mclk_in(mclk_in), .req_out(req));

  display_ctrl_irq_unit display_ctrl_irq_unit_inst (.mclk_in(mclk_in), .rst_n_in(rst_n), .req_in(req),
    .event_in(ev), .engine_on_in(eng), .xfer_op_in(op), .text_mode_in(txt), .rdata_out(rdata), .irq_out(irq));

  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction : xs

  // reference model, old values seen before this edge's updates
  always @(posedge mclk_in) begin
    if (!rst_n) begin
      m_en = 0;
      m_pend = 0;
      m_rdata = 0;
      m_irq = 0;
    end else begin
      m_irq = ((m_pend & m_en) != 0);
      if (req.rd) m_rdata = (req.addr == 8'hF0) ? m_en : (req.addr == 8'hF1) ? m_pend : 0;
      sh = (eng && (op inside {4'h0, 4'h1, 4'h4, 4'h8, 4'h9}) && ev.host_rw) || (!eng && txt && ev.font_done);
      if (req.wr && req.addr == 8'hF0) m_en = req.wdata[4:0];
      if (req.wr && req.addr == 8'hF1) m_pend &= ~int'(req.wdata[4:0]);
      m_pend |= {ev.key, ev.dma, ev.touch, ev.xfer_done, sh[0]};
    end
  end

  always @(posedge mclk_in) begin
    if (rnd_on) begin
      seed = xs(seed);
      ev <= seed[5:0] & seed[11:6] & seed[17:12];
      eng <= seed[18];
      op <= seed[22:19];
      txt <= seed[23];
    end
  end

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected at %0t: got %h want %h", $time, seen, exp);
    end
  endtask : check

  always @(negedge mclk_in) begin
    if (rst_n) begin
      check(rdata, 8'(m_rdata));
      check({7'h00, irq}, 8'(m_irq));
    end
  end

  task automatic wrap_up;
    $display("errors %0d tests_run %0d", errors, tests_run);
    if (errors == 0 && tests_run > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : wrap_up

  task automatic host_burst(input int n);
    for (int i = 0; i < n; i++) begin
      hs = xs(hs);
      host_model_inst.access(hs[3], (hs[1:0] == 2'h0) ? 8'h3C : {7'h78, hs[2]}, hs[15:8]);
    end
  endtask : host_burst

  initial begin
    hs = xs(32'hDEDB);
    repeat (20) @(posedge mclk_in);
    rst_n <= 1'b1;
    host_model_inst.access(1'b0, 8'hF0, 8'h00);
    host_model_inst.access(1'b1, 8'hF0, 8'hFF);
    host_model_inst.access(1'b0, 8'hF0, 8'h00);
    host_model_inst.access(1'b0, 8'hF1, 8'h00);
    rnd_on <= 1'b1;
    host_burst(1500);
    @(posedge mclk_in);
    rst_n <= 1'b0;
    repeat (3) @(posedge mclk_in);
    rst_n <= 1'b1;
    host_burst(1500);
    wrap_up();
  end
endmodule : tb_display_ctrl_irq_unit
